/* File: include/mts_defines.vh */
// Constants for the mode transition sequencer: mode codes, config fields,
// register offsets, status layout and reset values.
// Assumes the including file needs only `define macros, nothing else.
`ifndef MTS_DEFINES_VH
`define MTS_DEFINES_VH

// Device mode codes (4 bits)
`define MTS_MODE_RESET 4'h0
`define MTS_MODE_TEST 4'h1
`define MTS_MODE_SAFE 4'h2
`define MTS_MODE_DEFAULT_RUN_MODE 4'h3
`define MTS_MODE_RUN0 4'h4
`define MTS_MODE_RUN3 4'h7
`define MTS_MODE_HALT 4'h8
`define MTS_MODE_STOP 4'hA
`define MTS_MODE_STANDBY 4'hD

// Mode configuration word fields
`define MTS_CFG_W 9
`define MTS_CFG_FIRC 0
`define MTS_CFG_FXOSC 1
`define MTS_CFG_PLL 2
`define MTS_CFG_MVR 3
`define MTS_CFG_CFL_LO 4
`define MTS_CFG_DFL_LO 6
`define MTS_CFG_PDO 8

// Flash power mode encodings
`define MTS_FLA_PWRDN 2'h1
`define MTS_FLA_LOWPWR 2'h2
`define MTS_FLA_NORMAL 2'h3

// Register byte offsets
`define MTS_REG_CTRL 4'h0
`define MTS_REG_STATUS 4'h4
`define MTS_REG_MODES 4'h8

// Control register
`define MTS_CTRL_EN 0
`define MTS_CTRL_RST 1'h1

// Status register layout
`define MTS_ST_FIRC 0
`define MTS_ST_FXOSC 1
`define MTS_ST_MVR 2
`define MTS_ST_PLL 3
`define MTS_ST_CFL_LO 4
`define MTS_ST_DFL_LO 6
`define MTS_ST_BUSY 8
`define MTS_ST_STEP_LO 12

// Reset values of availability state
`define MTS_RST_FIRC 1'h1
`define MTS_RST_FXOSC 1'h0
`define MTS_RST_MVR 1'h1
`define MTS_RST_PLL 1'h0
`define MTS_RST_FLA 2'h3

// AXI responses
`define MTS_RESP_OKAY 2'h0
`define MTS_RESP_SLVERR 2'h2

`endif

/* File: design/mts_sequencer.v */
// Mode transition sequencer: middle steps of a mode change, from processor
// low-power entry to processor low-power exit, plus an AXI4-Lite slave.
// Assumes partners (core, power control unit, flash, peripheral clock logic)
// run on clk; oscillator and lock indications arrive asynchronously.
//
// Chosen here: the address map and register access over AXI4-Lite.
`include "mts_defines.vh"
`default_nettype none

// Function
// - After peripheral clock disable, a HALT target raises a halt request.
// - After peripheral clock disable, STOP or STANDBY targets raise stop request.
// - Low-power targets gate processor and memory clocks after acknowledge.
// - Processor and memory clocks stay on between software running modes.
// - After core entry, switch on oscillators newly needed; PLL excluded.
// - Wait for each new oscillator's stable flag, then set its availability.
// - Oscillators being switched off keep running through switch-on.
// - Regulator off-to-on: ask power unit, wait stable, set availability.
// - Regulator power-up only leaving HALT/STOP; RC oscillator forced on.
// - Leaving STANDBY the power unit alone powers the regulator.
// - Flash leaving low-power: request wake, state field becomes 11.
// - Flash stays low-power until regulator switch-on completes.
// - Illegal low-power/power-down flash moves are neither blocked nor flagged.
// - After oscillators and regulator, PLL off-to-on: start, wait lock, flag.
// - After regulator, signal mode change to power unit, wait its power-ups.
// - Pad power-down clear: restore pad outputs, switch on pad driver.
// - Peripheral clocks enabled only after regulator switch-on completes.
// - Peripheral clocks in powered domains wait for power unit completion.
// - HALT/STOP to user run: re-enable core clocks after flash switch-on.
// - Low-power to user run: request core exit after the clock step; STANDBY exits keep clocks off.
module mts_sequencer (
	input wire clk,
	input wire rst_n,
	// Start of the middle steps and the mode pair
	input wire seq_start,
	input wire [3:0] cur_mode,
	input wire [3:0] tgt_mode,
	input wire [`MTS_CFG_W-1:0] cur_cfg,
	input wire [`MTS_CFG_W-1:0] tgt_cfg,
	output reg seq_busy,
	output reg seq_done,
	// Processor core
	output reg cpu_halt_req,
	output reg cpu_stop_req,
	input wire cpu_lp_ack,
	output reg cpu_wake_req,
	input wire cpu_wake_ack,
	output reg cpu_clk_en,
	output reg mem_clk_en,
	// Oscillators and PLL
	output reg firc_en,
	output reg fxosc_en,
	input wire firc_stable,
	input wire fxosc_stable,
	output reg pll_start,
	input wire pll_lock,
	// Power control unit
	output reg mvr_pwrup_req,
	input wire mvr_stable,
	output reg pcu_mode_chg,
	input wire pcu_pwrup_done,
	// Flash modules, bit 0 code flash, bit 1 data flash
	output reg [1:0] flash_wake_req,
	input wire [1:0] flash_ready,
	// Pads and peripheral clocks
	output reg pad_restore,
	output reg pad_drv_on,
	output reg periph_en_req,
	input wire periph_en_ack,
	// AXI4-Lite slave
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);

localparam S_IDLE = 4'h0;
localparam S_CPU_ENTRY = 4'h1;
localparam S_CLK_OFF = 4'h2;
localparam S_OSC_ON = 4'h3;
localparam MAIN_REGULATOR_AVAILABLE_ON = 4'h4;
localparam S_FLASH_ON = 4'h5;
localparam S_PLL_ON = 4'h6;
localparam S_PD2_ON = 4'h7;
localparam S_PADS_ON = 4'h8;
localparam S_PERIPH_ON = 4'h9;
localparam S_CLK_ON = 4'hA;
localparam S_CPU_EXIT = 4'hB;

// User run modes RUN0..RUN3
function is_user_run;
	input [3:0] m;
	begin
		is_user_run = (m >= `MTS_MODE_RUN0) && (m <= `MTS_MODE_RUN3);
	end
endfunction

// HALT or STOP, the modes the regulator and core clocks come back from
function is_halt_stop;
	input [3:0] m;
	begin
		is_halt_stop = (m == `MTS_MODE_HALT) || (m == `MTS_MODE_STOP);
	end
endfunction

// Mapped register offsets
function addr_ok;
	input [3:0] a;
	begin
		addr_ok = (a == `MTS_REG_CTRL) || (a == `MTS_REG_STATUS) ||
			(a == `MTS_REG_MODES);
	end
endfunction

reg rst_s1_q;
reg rst_s2_q;
wire rst_i_n;

// Reset release through two flops; assertion stays asynchronous
always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		rst_s1_q <= 1'b0;
		rst_s2_q <= 1'b0;
	end else begin
		rst_s1_q <= 1'b1;
		rst_s2_q <= rst_s1_q;
	end
end
assign rst_i_n = rst_s2_q;

// Four-flop input filters for the analog stable and lock flags
wire [2:0] async_in;
wire [2:0] async_f;
assign async_in = {pll_lock, fxosc_stable, firc_stable};

genvar gi;
generate
	for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
		reg s1_q;
		reg s2_q;
		reg s3_q;
		reg f_q;
		// Change accepted only once stages two and three agree
		always @(posedge clk or negedge rst_i_n) begin
			if (!rst_i_n) begin
				s1_q <= 1'b0;
				s2_q <= 1'b0;
				s3_q <= 1'b0;
				f_q <= 1'b0;
			end else begin
				s1_q <= async_in[gi];
				s2_q <= s1_q;
				s3_q <= s2_q;
				if (s2_q == s3_q)
					f_q <= s3_q;
			end
		end
		assign async_f[gi] = f_q;
	end
endgenerate

wire firc_ok = async_f[0];
wire fxosc_ok = async_f[1];
wire lock_ok = async_f[2];

reg [3:0] state_q;
reg [3:0] cmode_q;
reg [3:0] tmode_q;
reg [`MTS_CFG_W-1:0] ccfg_q;
reg [`MTS_CFG_W-1:0] tcfg_q;
reg ctrl_en_q;
reg firc_av_q;
reg fxosc_av_q;
reg mvr_av_q;
reg pll_av_q;
reg [1:0] cfl_st_q;
reg [1:0] dfl_st_q;

// Decisions drawn from the latched mode pair
wire tgt_lp = (tmode_q == `MTS_MODE_HALT) || (tmode_q == `MTS_MODE_STOP) ||
	(tmode_q == `MTS_MODE_STANDBY);
wire need_firc = tcfg_q[`MTS_CFG_FIRC] & ~ccfg_q[`MTS_CFG_FIRC];
wire need_fx = tcfg_q[`MTS_CFG_FXOSC] & ~ccfg_q[`MTS_CFG_FXOSC];
wire need_pll = tcfg_q[`MTS_CFG_PLL] & ~ccfg_q[`MTS_CFG_PLL];
wire need_mvr = tcfg_q[`MTS_CFG_MVR] & ~ccfg_q[`MTS_CFG_MVR] &
	is_halt_stop(cmode_q);
wire [1:0] ccfl = ccfg_q[`MTS_CFG_CFL_LO+1:`MTS_CFG_CFL_LO];
wire [1:0] tcfl = tcfg_q[`MTS_CFG_CFL_LO+1:`MTS_CFG_CFL_LO];
wire [1:0] cdfl = ccfg_q[`MTS_CFG_DFL_LO+1:`MTS_CFG_DFL_LO];
wire [1:0] tdfl = tcfg_q[`MTS_CFG_DFL_LO+1:`MTS_CFG_DFL_LO];
// Only a move to normal wakes a flash; other moves pass unchecked
wire [1:0] need_fla = {(cdfl != `MTS_FLA_NORMAL) && (tdfl == `MTS_FLA_NORMAL),
	(ccfl != `MTS_FLA_NORMAL) && (tcfl == `MTS_FLA_NORMAL)};
wire to_run = is_user_run(tmode_q);
wire from_lp = is_halt_stop(cmode_q) || (cmode_q == `MTS_MODE_STANDBY);

// Sequencer; one step at a time in dependency order
always @(posedge clk or negedge rst_i_n) begin
	if (!rst_i_n) begin
		state_q <= S_IDLE;
		cmode_q <= `MTS_MODE_RESET;
		tmode_q <= `MTS_MODE_RESET;
		ccfg_q <= {`MTS_CFG_W{1'b0}};
		tcfg_q <= {`MTS_CFG_W{1'b0}};
		seq_busy <= 1'b0;
		seq_done <= 1'b0;
		cpu_halt_req <= 1'b0;
		cpu_stop_req <= 1'b0;
		cpu_wake_req <= 1'b0;
		cpu_clk_en <= 1'b1;
		mem_clk_en <= 1'b1;
		firc_en <= `MTS_RST_FIRC;
		fxosc_en <= `MTS_RST_FXOSC;
		pll_start <= 1'b0;
		mvr_pwrup_req <= 1'b0;
		pcu_mode_chg <= 1'b0;
		flash_wake_req <= 2'h0;
		pad_restore <= 1'b0;
		pad_drv_on <= 1'b1;
		periph_en_req <= 1'b0;
		firc_av_q <= `MTS_RST_FIRC;
		fxosc_av_q <= `MTS_RST_FXOSC;
		mvr_av_q <= `MTS_RST_MVR;
		pll_av_q <= `MTS_RST_PLL;
		cfl_st_q <= `MTS_RST_FLA;
		dfl_st_q <= `MTS_RST_FLA;
	end else begin
		seq_done <= 1'b0;
		pad_restore <= 1'b0;
		case (state_q)
		S_IDLE: begin
			// Start ignored while software holds the block disabled
			if (seq_start && ctrl_en_q) begin
				cmode_q <= cur_mode;
				tmode_q <= tgt_mode;
				ccfg_q <= cur_cfg;
				tcfg_q <= tgt_cfg;
				seq_busy <= 1'b1;
				state_q <= S_CPU_ENTRY;
			end
		end
		S_CPU_ENTRY: begin
			if (!tgt_lp) begin
				state_q <= S_OSC_ON;
			end else if (cpu_lp_ack && (cpu_halt_req || cpu_stop_req)) begin
				// Ack means core has drained its bus traffic
				cpu_halt_req <= 1'b0;
				cpu_stop_req <= 1'b0;
				state_q <= S_CLK_OFF;
			end else if (tmode_q == `MTS_MODE_HALT) begin
				cpu_halt_req <= 1'b1;
			end else begin
				cpu_stop_req <= 1'b1;
			end
		end
		S_CLK_OFF: begin
			// Only low-power targets reach here; run-mode moves keep clocks
			cpu_clk_en <= 1'b0;
			mem_clk_en <= 1'b0;
			state_q <= S_OSC_ON;
		end
		S_OSC_ON: begin
			// Enables only rise here; sources leaving stay up
			if (need_firc)
				firc_en <= 1'b1;
			if (need_fx)
				fxosc_en <= 1'b1;
			if (need_firc && firc_ok)
				firc_av_q <= 1'b1;
			if (need_fx && fxosc_ok)
				fxosc_av_q <= 1'b1;
			// Later steps wait for every new source to settle
			if ((!need_firc || firc_ok) && (!need_fx || fxosc_ok))
				state_q <= MAIN_REGULATOR_AVAILABLE_ON;
		end
		MAIN_REGULATOR_AVAILABLE_ON: begin
			// STANDBY exits never get here as a regulator step
			if (!need_mvr) begin
				state_q <= S_FLASH_ON;
			end else if (mvr_pwrup_req && mvr_stable) begin
				mvr_pwrup_req <= 1'b0;
				mvr_av_q <= 1'b1;
				state_q <= S_FLASH_ON;
			end else begin
				// Regulator needs the RC oscillator for its status
				firc_en <= 1'b1;
				mvr_pwrup_req <= 1'b1;
			end
		end
		S_FLASH_ON: begin
			// Reached only after the regulator step has closed
			flash_wake_req <= need_fla & ~flash_ready;
			if (need_fla[0] && flash_ready[0])
				cfl_st_q <= `MTS_FLA_NORMAL;
			if (need_fla[1] && flash_ready[1])
				dfl_st_q <= `MTS_FLA_NORMAL;
			if ((need_fla & ~flash_ready) == 2'h0)
				state_q <= S_PLL_ON;
		end
		S_PLL_ON: begin
			// Oscillator and regulator steps are both behind us
			if (!need_pll) begin
				state_q <= S_PD2_ON;
			end else if (pll_start && lock_ok) begin
				pll_start <= 1'b0;
				pll_av_q <= 1'b1;
				state_q <= S_PD2_ON;
			end else begin
				pll_start <= 1'b1;
			end
		end
		S_PD2_ON: begin
			// Power unit decides on domain two; we wait for its word
			if (pcu_mode_chg && pcu_pwrup_done) begin
				pcu_mode_chg <= 1'b0;
				state_q <= S_PADS_ON;
			end else begin
				pcu_mode_chg <= 1'b1;
			end
		end
		S_PADS_ON: begin
			if (!tcfg_q[`MTS_CFG_PDO]) begin
				pad_restore <= 1'b1;
				pad_drv_on <= 1'b1;
			end
			state_q <= S_PERIPH_ON;
		end
		S_PERIPH_ON: begin
			// Domain power-up already confirmed in the previous steps
			if (periph_en_req && periph_en_ack) begin
				periph_en_req <= 1'b0;
				state_q <= S_CLK_ON;
			end else begin
				periph_en_req <= 1'b1;
			end
		end
		S_CLK_ON: begin
			// Flash switch-on lies earlier in the chain
			if (is_halt_stop(cmode_q) && to_run) begin
				cpu_clk_en <= 1'b1;
				mem_clk_en <= 1'b1;
			end
			state_q <= S_CPU_EXIT;
		end
		S_CPU_EXIT: begin
			if (!(from_lp && to_run)) begin
				seq_busy <= 1'b0;
				seq_done <= 1'b1;
				state_q <= S_IDLE;
			end else if (cpu_wake_req && cpu_wake_ack) begin
				cpu_wake_req <= 1'b0;
				seq_busy <= 1'b0;
				seq_done <= 1'b1;
				state_q <= S_IDLE;
			end else begin
				cpu_wake_req <= 1'b1;
			end
		end
		default: begin
			state_q <= S_IDLE;
		end
		endcase
	end
end

// AXI4-Lite slave; address and data may arrive in either order
reg aw_got_q;
reg w_got_q;
reg [3:0] awaddr_q;
reg [31:0] wdata_q;
reg wstrb0_q;

assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
assign s_axi_wready = !w_got_q && !s_axi_bvalid;
assign s_axi_arready = !s_axi_rvalid;

wire [31:0] status_word = {16'h0, state_q, 3'h0, seq_busy, dfl_st_q,
	cfl_st_q, pll_av_q, mvr_av_q, fxosc_av_q, firc_av_q};
wire [31:0] modes_word = {24'h0, tmode_q, cmode_q};

always @(posedge clk or negedge rst_i_n) begin
	if (!rst_i_n) begin
		aw_got_q <= 1'b0;
		w_got_q <= 1'b0;
		awaddr_q <= 4'h0;
		wdata_q <= 32'h0;
		wstrb0_q <= 1'b0;
		ctrl_en_q <= `MTS_CTRL_RST;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `MTS_RESP_OKAY;
	end else begin
		if (s_axi_awvalid && s_axi_awready) begin
			aw_got_q <= 1'b1;
			awaddr_q <= s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_got_q <= 1'b1;
			wdata_q <= s_axi_wdata;
			wstrb0_q <= s_axi_wstrb[0];
		end
		// Commit once both halves are held
		if (aw_got_q && w_got_q) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			s_axi_bvalid <= 1'b1;
			if (addr_ok(awaddr_q))
				s_axi_bresp <= `MTS_RESP_OKAY;
			else
				s_axi_bresp <= `MTS_RESP_SLVERR;
			if (awaddr_q == `MTS_REG_CTRL && wstrb0_q)
				ctrl_en_q <= wdata_q[`MTS_CTRL_EN];
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
end

// Read channel; status is a live snapshot at address acceptance
always @(posedge clk or negedge rst_i_n) begin
	if (!rst_i_n) begin
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h0;
		s_axi_rresp <= `MTS_RESP_OKAY;
	end else if (s_axi_arvalid && s_axi_arready) begin
		s_axi_rvalid <= 1'b1;
		s_axi_rresp <= addr_ok(s_axi_araddr) ? `MTS_RESP_OKAY :
			`MTS_RESP_SLVERR;
		case (s_axi_araddr)
		`MTS_REG_CTRL: s_axi_rdata <= {31'h0, ctrl_en_q};
		`MTS_REG_STATUS: s_axi_rdata <= status_word;
		`MTS_REG_MODES: s_axi_rdata <= modes_word;
		default: s_axi_rdata <= 32'h0;
		endcase
	end else if (s_axi_rvalid && s_axi_rready) begin
		s_axi_rvalid <= 1'b0;
	end
end

endmodule
`default_nettype wire

/* File: sim/mts_monitor.sv */
// Checker for the mode transition sequencer, bound to its ports.
// Assumes the bench holds mode and config inputs steady while busy.
`include "mts_defines.vh"
`default_nettype none
module mts_monitor (
	input wire clk,
	input wire rst_n,
	input wire seq_busy,
	input wire seq_done,
	input wire [3:0] cur_mode,
	input wire [3:0] tgt_mode,
	input wire [`MTS_CFG_W-1:0] cur_cfg,
	input wire [`MTS_CFG_W-1:0] tgt_cfg,
	input wire cpu_halt_req,
	input wire cpu_stop_req,
	input wire cpu_wake_req,
	input wire cpu_clk_en,
	input wire mem_clk_en,
	input wire firc_en,
	input wire fxosc_en,
	input wire pll_start,
	input wire mvr_pwrup_req,
	input wire pcu_mode_chg,
	input wire [1:0] flash_wake_req,
	input wire periph_en_req
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// Mode classes of the pair under way
	wire lp_cur = cur_mode == `MTS_MODE_HALT || cur_mode == `MTS_MODE_STOP;
	wire lp_tgt = tgt_mode == `MTS_MODE_HALT || tgt_mode == `MTS_MODE_STOP
		|| tgt_mode == `MTS_MODE_STANDBY;
	wire run_pair = cur_mode >= `MTS_MODE_SAFE && cur_mode <= `MTS_MODE_RUN3
		&& tgt_mode >= `MTS_MODE_SAFE && tgt_mode <= `MTS_MODE_RUN3;
	property p_halt;
		$rose(cpu_halt_req) |-> tgt_mode == `MTS_MODE_HALT;
	endproperty
	a_halt: assert property (p_halt) else $error("halt req bad");
	property p_stop;
		$rose(cpu_stop_req) |-> tgt_mode >= `MTS_MODE_STOP;
	endproperty
	a_stop: assert property (p_stop) else $error("stop req bad");
	property p_gate;
		$fell(cpu_clk_en) |-> lp_tgt && !cpu_halt_req && !cpu_stop_req;
	endproperty
	a_gate: assert property (p_gate) else $error("gated early");
	property p_run;
		seq_busy && run_pair |-> cpu_clk_en && mem_clk_en;
	endproperty
	a_run: assert property (p_run) else $error("clock lost");
	property p_osc;
		$rose(fxosc_en) |-> !cur_cfg[`MTS_CFG_FXOSC] && tgt_cfg[`MTS_CFG_FXOSC];
	endproperty
	a_osc: assert property (p_osc) else $error("xtal on bad");
	property p_keep;
		!$fell(firc_en) && !$fell(fxosc_en);
	endproperty
	a_keep: assert property (p_keep) else $error("osc dropped");
	property p_mvr;
		$rose(mvr_pwrup_req) |-> lp_cur && firc_en
			&& !cur_cfg[`MTS_CFG_MVR] && tgt_cfg[`MTS_CFG_MVR];
	endproperty
	a_mvr: assert property (p_mvr) else $error("mvr req bad");
	property p_fla;
		|flash_wake_req |-> !mvr_pwrup_req;
	endproperty
	a_fla: assert property (p_fla) else $error("flash early");
	property p_pll;
		$rose(pll_start) |-> !mvr_pwrup_req
			&& !cur_cfg[`MTS_CFG_PLL] && tgt_cfg[`MTS_CFG_PLL];
	endproperty
	a_pll: assert property (p_pll) else $error("pll start bad");
	property p_per;
		periph_en_req |-> !mvr_pwrup_req && !pcu_mode_chg;
	endproperty
	a_per: assert property (p_per) else $error("periph early");
	property p_wake;
		$rose(cpu_wake_req) && lp_cur |-> cpu_clk_en && mem_clk_en;
	endproperty
	a_wake: assert property (p_wake) else $error("wake early");
	property p_done;
		seq_done |-> !pcu_mode_chg ##1 !seq_done;
	endproperty
	a_done: assert property (p_done) else $error("done bad");
	// Main paths seen
	c_mvr: cover property ($rose(mvr_pwrup_req));
	c_pll: cover property ($rose(pll_start));
	c_wake: cover property ($rose(cpu_wake_req));
endmodule
bind mts_sequencer mts_monitor i_mon (.*);
`default_nettype wire

/* File: sim/mts_partner_model.sv */
// Far side: core, oscillators, PLL, power unit, flash, peripherals.
// Each request is answered after it has stood dly cycles, level held.
`default_nettype none
module mts_partner_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] dly,
	input wire logic [9:0] req,
	output logic [9:0] ack
);
	logic [7:0] cnt [10];
	// Age of each request; an answer never comes before dly cycles
	always_ff @(posedge clk or negedge rst_n) begin
		for (int i = 0; i < 10; i++) begin
			if (!rst_n)
				cnt[i] <= 8'h00;
			else if (!req[i])
				cnt[i] <= 8'h00;
			else if (cnt[i] != 8'hFF)
				cnt[i] <= cnt[i] + 8'h01;
		end
	end
	// Core acks once its bus work drains; power unit reports when done
	always_comb begin
		for (int i = 0; i < 10; i++)
			ack[i] = req[i] && cnt[i] >= dly;
	end
endmodule
`default_nettype wire

/* File: sim/mode_transition_sequencer_test.sv */
// Self-checking bench for the mode transition sequencer.
// Assumes the partner model answers every handshake; AXI master is here.
`include "mts_defines.vh"
`default_nettype none
module mode_transition_sequencer_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, seq_start, cpu_lp_ack, cpu_wake_ack, firc_stable;
	logic fxosc_stable, pll_lock, mvr_stable, pcu_pwrup_done, periph_en_ack;
	logic [3:0] cur_mode, tgt_mode, s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
	logic [8:0] cur_cfg, tgt_cfg;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_rready, seq_busy, seq_done, cpu_halt_req, cpu_stop_req;
	logic cpu_wake_req, cpu_clk_en, mem_clk_en, firc_en, fxosc_en, pll_start;
	logic mvr_pwrup_req, pcu_mode_chg, pad_restore, pad_drv_on, periph_en_req;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, ce, fx, pl;
	logic [1:0] flash_wake_req, flash_ready, s_axi_bresp, s_axi_rresp, r;
	logic [1:0] fl_on;
	logic [7:0] dly;
	logic [9:0] req, ack;
	logic [31:0] rn;
	integer seed, n_fail, n_checks;
	mts_sequencer i_dut (.*);
	mts_partner_model i_far (.clk(clk), .rst_n(rst_n), .dly(dly),
		.req(req), .ack(ack));
	// Far side wiring; handshake answers come from the partner model
	assign req = {flash_wake_req, periph_en_req, pcu_mode_chg, mvr_pwrup_req,
		pll_start, fxosc_en, firc_en, cpu_wake_req, cpu_halt_req | cpu_stop_req};
	assign {periph_en_ack, pcu_pwrup_done, mvr_stable, pll_lock, fxosc_stable,
		firc_stable, cpu_wake_ack, cpu_lp_ack} = ack[7:0];
	// Flash awake if normal in the mode left, or once its wake is answered;
	// a sleeping flash must read not ready or no wake is ever asked
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			fl_on <= 2'h3;
		else if (seq_start)
			fl_on <= {cur_cfg[7:6] == 2'h3, cur_cfg[5:4] == 2'h3};
		else
			fl_on <= fl_on | ack[9:8];
	end
	assign flash_ready = fl_on | ack[9:8];
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// AXI write: address and data offered together, bready held for bvalid
	task wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task rd(input logic [3:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// Events a mode pair must show: pads, flashes, wake, pll, mvr, stop, halt
	function automatic logic [7:0] ev(input logic [3:0] cm, input logic [3:0] tm,
		input logic [8:0] cc, input logic [8:0] tc);
		logic lp, run;
		lp = cm == `MTS_MODE_HALT || cm == `MTS_MODE_STOP;
		run = tm >= `MTS_MODE_RUN0 && tm <= `MTS_MODE_RUN3;
		ev[0] = tm == `MTS_MODE_HALT;
		ev[1] = tm == `MTS_MODE_STOP || tm == `MTS_MODE_STANDBY;
		ev[2] = lp && !cc[3] && tc[3];
		ev[3] = !cc[2] && tc[2];
		ev[4] = (lp || cm == `MTS_MODE_STANDBY) && run;
		ev[5] = cc[5:4] != 2'h3 && tc[5:4] == 2'h3;
		ev[6] = cc[7:6] != 2'h3 && tc[7:6] == 2'h3;
		ev[7] = !tc[8];
	endfunction
	// Legal flash moves only: normal or low-power
	function automatic logic [8:0] cfg(input logic [8:0] x);
		cfg = {x[8], 1'b1, x[6], 1'b1, x[4:0]};
	endfunction
	task seq(input logic [3:0] cm, input logic [3:0] tm,
		input logic [8:0] cc, input logic [8:0] tc);
		logic [7:0] saw, e;
		int k;
		e = ev(cm, tm, cc, tc);
		saw = 8'h00;
		k = 0;
		@(posedge clk);
		cur_mode <= cm;
		tgt_mode <= tm;
		cur_cfg <= cc;
		tgt_cfg <= tc;
		seq_start <= 1'b1;
		dly <= 8'h01 + 8'($random(seed) & 3);
		do begin
			@(posedge clk);
			seq_start <= 1'b0;
			saw |= {pad_restore, flash_wake_req, cpu_wake_req, pll_start,
				mvr_pwrup_req, cpu_stop_req, cpu_halt_req};
			k++;
		end while (seq_done !== 1'b1 && k < 500);
		chk(k < 500, 1'b1);
		chk(saw, e);
		if (e[0] || e[1])
			ce = 1'b0;
		else if (e[4] && cm != `MTS_MODE_STANDBY)
			ce = 1'b1;
		fx |= !cc[1] && tc[1];
		pl |= e[3];
		chk({cpu_clk_en, mem_clk_en}, {ce, ce});
		chk(fxosc_en, fx);
		chk({seq_busy, pad_drv_on}, 2'b01);
		rd(`MTS_REG_STATUS);
		chk(d[8:0], {5'h0F, pl, 1'b1, fx, 1'b1});
		rd(`MTS_REG_MODES);
		chk(d[7:0], {tm, cm});
	endtask
	task do_reset;
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		{ce, fx, pl} = 3'h4;
	endtask
	initial begin
		#200000;
		n_fail++;
		stop_test;
	end
	initial begin
		{rst_n, seq_start, s_axi_awvalid, s_axi_wvalid} = 4'h0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
		{cur_mode, tgt_mode, s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 20'h0;
		{cur_cfg, tgt_cfg, s_axi_wdata} = 50'h0;
		dly = 8'h01;
		seed = 32'h8F2D;
		n_fail = 0;
		n_checks = 0;
		do_reset;
		rd(`MTS_REG_STATUS);
		chk(d[8:0], 9'h0F5);
		rd(4'hC);
		chk({r, d}, {`MTS_RESP_SLVERR, 32'h0});
		wr(`MTS_REG_CTRL, 32'h0, 4'h0);
		rd(`MTS_REG_CTRL);
		chk({r, d[0]}, {`MTS_RESP_OKAY, 1'b1});
		// Disabled block must ignore a start
		wr(`MTS_REG_CTRL, 32'h0, 4'h1);
		rd(`MTS_REG_CTRL);
		chk({r, d[0]}, {`MTS_RESP_OKAY, 1'b0});
		seq_start <= 1'b1;
		repeat (3) @(posedge clk);
		chk(seq_busy, 1'b0);
		seq_start <= 1'b0;
		wr(`MTS_REG_CTRL, 32'h1, 4'h1);
		seq(`MTS_MODE_DEFAULT_RUN_MODE, `MTS_MODE_RUN0, 9'h1F9, 9'h1F9);
		seq(`MTS_MODE_RUN0, `MTS_MODE_HALT, 9'h0F9, 9'h0A1);
		seq(`MTS_MODE_HALT, 4'h5, 9'h0A1, 9'h0FF);
		seq(4'h5, `MTS_MODE_STOP, 9'h0FF, 9'h151);
		seq(`MTS_MODE_STOP, 4'h6, 9'h151, 9'h0FD);
		seq(4'h6, `MTS_MODE_STANDBY, 9'h0FD, 9'h150);
		seq(`MTS_MODE_STANDBY, `MTS_MODE_RUN0, 9'h150, 9'h0F9);
		do_reset;
		for (int i = 0; i < 20; i++) begin
			rn = $random(seed);
			seq(4'h2 + 4'(rn[31:28] % 6), 4'h2 + 4'(rn[27:24] % 6),
				cfg(rn[8:0]), cfg(rn[17:9]));
		end
		stop_test;
	end
endmodule
`default_nettype wire
